/* File: seq_monitor.sv */
// pin-level assertions for the eeprom command sequencer
`timescale 1ns/1ps
`default_nettype none
module seq_monitor #(
    parameter integer WC_CYCLES = 600
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic so,
    input wire logic so_oe,
    input wire logic write_busy
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [31:0] busy_cnt_q;
    // length of the running busy period
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_cnt_q <= 32'h0;
        end else begin
            busy_cnt_q <= write_busy ? busy_cnt_q + 32'h1 : 32'h0;
        end
    end
    oe_idle_a: assert property (cs_n [*6] |-> !so_oe)
        else $error("so driven while deselected");
    oe_start_a: assert property ($rose(so_oe) |-> !cs_n && !sck)
        else $error("so enabled outside a clock low phase");
    so_shift_a: assert property (so_oe && $changed(so) |-> !sck)
        else $error("so changed while clock high");
    oe_drop_a: assert property ($rose(cs_n) |-> ##[1:5] !so_oe)
        else $error("so still driven after deselect");
    oe_select_a: assert property (so_oe |-> !$past(cs_n, 6))
        else $error("so driven without a selected frame");
    busy_start_a: assert property ($rose(write_busy) |-> cs_n && $past(cs_n, 2))
        else $error("write cycle began while selected");
    busy_hold_a: assert property ($rose(write_busy) |=> write_busy [*8])
        else $error("write cycle cut short");
    busy_len_a: assert property ($fell(write_busy) |-> busy_cnt_q == WC_CYCLES)
        else $error("write cycle length wrong");
    busy_cap_a: assert property (busy_cnt_q <= WC_CYCLES)
        else $error("write cycle too long");
    cover property ($rose(write_busy));
    cover property ($fell(write_busy));
    cover property ($rose(so_oe));
endmodule
bind spi_eeprom_rw_sequencer seq_monitor #(.WC_CYCLES(WC_CYCLES)) seq_monitor_inst (.clk(clk),
    .rst_n(rst_n), .cs_n(cs_n), .sck(sck), .so(so), .so_oe(so_oe), .write_busy(write_busy));
`default_nettype wire

/* File: spi_eeprom_defines.vh */
// constants for the serial eeprom command sequencer
`ifndef SPI_EEPROM_DEFINES_VH
`define SPI_EEPROM_DEFINES_VH
// array geometry
`define ADDR_W 16
`define PAGE_W 7
// opcode low bits, upper nibble must be zero, bit 3 ignored
`define OP_SET_LATCH 3'h6
`define OP_CLR_LATCH 3'h4
`define OP_STAT_RD 3'h5
`define OP_STAT_WR 3'h1
`define OP_ARRAY_RD 3'h3
`define OP_ARRAY_WR 3'h2
// status byte layout
`define ST_BUSY 0
`define ST_LATCH 1
`define ST_GUARD_LO 2
`define ST_GUARD_HI 3
`define ST_PROT_EN 7
`define ST_BUSY_VAL 8'hFF
// reset values of the nonvolatile status bits
`define RST_GUARD 2'h0
`define RST_PROT_EN 1'b0
// self-timed write cycle
`define WRITE_TIME_US 5000
`define CLK_MHZ 10
`define WRITE_CYCLES (`WRITE_TIME_US * `CLK_MHZ)
`endif

/* File: spi_eeprom_rw_sequencer.v */
// serial eeprom command sequencer with array, page buffer and write timer
//
// Summary of operation
// - read opcode, address, then data out msb first
// - si ignored after read address received
// - read address advances after every byte
// - read address wraps from top to zero
// - write needs latch set and unguarded address
// - busy cycle accepts only status read
// - programming starts only on select rising
// - status bit 0 shows write in progress
// - page write steps only seven low bits
// - over 128 bytes wraps within page
// - write cycle end clears enable latch
// - write without latch ignored until deselect
// - restart only on new select falling edge
// - opcode decode with bit 3 ignored
// - status byte field layout
// - guard levels quarter, half, whole array
// - status write gated by pin and enable
`timescale 1ns/1ps
`default_nettype none
`include "spi_eeprom_defines.vh"

module spi_eeprom_rw_sequencer #(
    parameter integer WC_CYCLES = `WRITE_CYCLES
) (
    input wire clk,
    input wire rst_n,
    input wire ce,
    input wire cs_n,
    input wire sck,
    input wire si,
    input wire protect_pin_n,
    output reg so,
    output reg so_oe,
    output reg write_busy
);

    // sequencer states
    localparam [3:0] S_IDLE = 4'h0;
    localparam [3:0] S_CMD = 4'h1;
    localparam [3:0] S_ADDR = 4'h2;
    localparam [3:0] S_RDATA = 4'h3;
    localparam [3:0] S_WDATA = 4'h4;
    localparam [3:0] S_STATUS = 4'h5;
    localparam [3:0] S_SRWR = 4'h6;
    localparam [3:0] S_IGNORE = 4'h7;
    localparam integer PAGE_N = 1 << `PAGE_W;
    // last count of the timed cycle, cut to the timer width
    localparam integer WC_LAST_I = WC_CYCLES - 1;
    localparam [19:0] WC_LAST = WC_LAST_I[19:0];

    // guard level test on the two top address bits
    function guarded;
        input [1:0] top;
        input [1:0] lvl;
        begin
            case (lvl)
                2'h1: guarded = (top == 2'h3);
                2'h2: guarded = top[1];
                2'h3: guarded = 1'b1;
                default: guarded = 1'b0;
            endcase
        end
    endfunction

    // opcode match, upper nibble zero and bit 3 don't care
    function op_is;
        input [7:0] op;
        input [2:0] code;
        begin
            op_is = (op[7:4] == 4'h0) && (op[2:0] == code);
        end
    endfunction

    // array and page buffer
    reg [7:0] mem [0:(1 << `ADDR_W) - 1];
    reg [7:0] pbuf [0:PAGE_N - 1];
    // synchroniser stages
    reg cs_s1, cs_s2, cs_s3;
    reg sck_s1, sck_s2, sck_s3;
    reg si_s1, si_s2;
    reg wp_s1, wp_s2;
    // sequencer, address and write cycle state
    reg [3:0] state_q;
    reg [2:0] bit_q;
    reg ab_q;
    reg is_wr_q;
    reg [6:0] rx_q;
    reg [7:0] tx_q;
    reg [`ADDR_W-1:0] addr_q;
    reg [PAGE_N-1:0] pval_q;
    reg got_q;
    reg [7:0] sr_new_q;
    reg wel_q;
    reg [1:0] guard_q;
    reg prot_en_q;
    reg sr_mode_q;
    reg [19:0] timer_q;
    reg [`PAGE_W:0] cp_idx_q;
    reg [`ADDR_W-`PAGE_W-1:0] cp_page_q;

    // edge detects and datapath helpers
    wire cs_fall = cs_s3 & ~cs_s2;
    wire cs_rise = ~cs_s3 & cs_s2;
    wire sck_rise = ~sck_s3 & sck_s2;
    wire sck_fall = sck_s3 & ~sck_s2;
    wire [7:0] rx_next = {rx_q, si_s2};
    wire shifting = (state_q != S_IDLE) && (state_q != S_IGNORE);
    wire byte_done = ce & ~cs_fall & ~cs_rise & sck_rise & shifting & (bit_q == 3'h7);
    wire [15:0] addr_full = {addr_q[7:0], rx_next};
    wire [`ADDR_W-1:0] addr_inc = addr_q + 16'h0001;
    wire [7:0] status_byte = write_busy ? `ST_BUSY_VAL :
        {prot_en_q, 3'h0, guard_q, wel_q, 1'b0};
    wire sr_blocked = prot_en_q & ~wp_s2;
    wire pb_we = byte_done & (state_q == S_WDATA);
    wire cp_done = cp_idx_q[`PAGE_W];
    wire mem_we = ce & write_busy & ~sr_mode_q & ~cp_done & pval_q[cp_idx_q[`PAGE_W-1:0]];

    // page buffer, filled while a write transfer runs
    always @(posedge clk) begin
        if (pb_we) begin
            pbuf[addr_q[`PAGE_W-1:0]] <= rx_next;
        end
    end

    // array update, one buffered byte per cycle during the busy phase
    always @(posedge clk) begin
        if (mem_we) begin
            mem[{cp_page_q, cp_idx_q[`PAGE_W-1:0]}] <= pbuf[cp_idx_q[`PAGE_W-1:0]];
        end
    end

    // two-stage synchronisers, third stage only for edges
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cs_s1 <= 1'b1;
            cs_s2 <= 1'b1;
            cs_s3 <= 1'b1;
            sck_s1 <= 1'b0;
            sck_s2 <= 1'b0;
            sck_s3 <= 1'b0;
            si_s1 <= 1'b0;
            si_s2 <= 1'b0;
            wp_s1 <= 1'b1;
            wp_s2 <= 1'b1;
        end else if (ce) begin
            cs_s1 <= cs_n;
            cs_s2 <= cs_s1;
            cs_s3 <= cs_s2;
            sck_s1 <= sck;
            sck_s2 <= sck_s1;
            sck_s3 <= sck_s2;
            si_s1 <= si;
            si_s2 <= si_s1;
            wp_s1 <= protect_pin_n;
            wp_s2 <= wp_s1;
        end
    end

    // serial sequencer and write cycle engine
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= S_IDLE;
            bit_q <= 3'h0;
            ab_q <= 1'b0;
            is_wr_q <= 1'b0;
            rx_q <= 7'h00;
            tx_q <= 8'h00;
            addr_q <= 16'h0000;
            pval_q <= {PAGE_N{1'b0}};
            got_q <= 1'b0;
            sr_new_q <= 8'h00;
            wel_q <= 1'b0;
            guard_q <= `RST_GUARD;
            prot_en_q <= `RST_PROT_EN;
            sr_mode_q <= 1'b0;
            timer_q <= 20'h00000;
            cp_idx_q <= {(`PAGE_W+1){1'b0}};
            cp_page_q <= {(`ADDR_W-`PAGE_W){1'b0}};
            write_busy <= 1'b0;
            so <= 1'b0;
            so_oe <= 1'b0;
        end else if (ce) begin
            if (cs_fall) begin
                state_q <= S_CMD;
                bit_q <= 3'h0;
                got_q <= 1'b0;
            end else if (cs_rise) begin
                state_q <= S_IDLE;
                so_oe <= 1'b0;
                // start the timed cycle only once select is released
                if (state_q == S_WDATA && got_q) begin
                    write_busy <= 1'b1;
                    sr_mode_q <= 1'b0;
                    timer_q <= 20'h00000;
                    cp_idx_q <= {(`PAGE_W+1){1'b0}};
                    cp_page_q <= addr_q[`ADDR_W-1:`PAGE_W];
                end else if (state_q == S_SRWR && got_q && !sr_blocked) begin
                    write_busy <= 1'b1;
                    sr_mode_q <= 1'b1;
                    timer_q <= 20'h00000;
                    cp_idx_q <= {(`PAGE_W+1){1'b0}};
                end
            end else if (sck_rise && shifting) begin
                bit_q <= bit_q + 3'h1;
                rx_q <= rx_next[6:0];
                if (bit_q == 3'h7) begin
                    case (state_q)
                        S_CMD: begin
                            ab_q <= 1'b0;
                            if (write_busy && !op_is(rx_next, `OP_STAT_RD)) begin
                                state_q <= S_IGNORE;
                            end else if (op_is(rx_next, `OP_STAT_RD)) begin
                                tx_q <= status_byte;
                                state_q <= S_STATUS;
                            end else if (op_is(rx_next, `OP_SET_LATCH)) begin
                                wel_q <= 1'b1;
                                state_q <= S_IGNORE;
                            end else if (op_is(rx_next, `OP_CLR_LATCH)) begin
                                wel_q <= 1'b0;
                                state_q <= S_IGNORE;
                            end else if (op_is(rx_next, `OP_STAT_WR)) begin
                                state_q <= wel_q ? S_SRWR : S_IGNORE;
                            end else if (op_is(rx_next, `OP_ARRAY_RD)) begin
                                is_wr_q <= 1'b0;
                                state_q <= S_ADDR;
                            end else if (op_is(rx_next, `OP_ARRAY_WR) && wel_q) begin
                                is_wr_q <= 1'b1;
                                pval_q <= {PAGE_N{1'b0}};
                                state_q <= S_ADDR;
                            end else begin
                                state_q <= S_IGNORE;
                            end
                        end
                        S_ADDR: begin
                            addr_q <= addr_full;
                            ab_q <= 1'b1;
                            if (ab_q) begin
                                if (!is_wr_q) begin
                                    tx_q <= mem[addr_full];
                                    state_q <= S_RDATA;
                                end else if (guarded(addr_full[15:14], guard_q)) begin
                                    state_q <= S_IGNORE;
                                end else begin
                                    state_q <= S_WDATA;
                                end
                            end
                        end
                        S_RDATA: begin
                            addr_q <= addr_inc;
                            tx_q <= mem[addr_inc];
                        end
                        S_WDATA: begin
                            pval_q[addr_q[`PAGE_W-1:0]] <= 1'b1;
                            addr_q[`PAGE_W-1:0] <= addr_q[`PAGE_W-1:0] + 7'h01;
                            got_q <= 1'b1;
                        end
                        S_SRWR: begin
                            if (!got_q) begin
                                sr_new_q <= rx_next;
                            end
                            got_q <= 1'b1;
                        end
                        default: begin
                            tx_q <= status_byte;
                        end
                    endcase
                end
            end else if (sck_fall && (state_q == S_RDATA || state_q == S_STATUS)) begin
                so <= tx_q[7];
                so_oe <= 1'b1;
                tx_q <= {tx_q[6:0], 1'b0};
            end
            // timed write cycle: copy buffered bytes, then wait out the time
            // counts every enabled cycle, so select edges do not stretch it
            if (write_busy) begin
                if (!cp_done) begin
                    cp_idx_q <= cp_idx_q + 8'h01;
                end
                timer_q <= timer_q + 20'h00001;
                if (timer_q >= WC_LAST) begin
                    write_busy <= 1'b0;
                    wel_q <= 1'b0;
                    if (sr_mode_q) begin
                        guard_q <= {sr_new_q[`ST_GUARD_HI], sr_new_q[`ST_GUARD_LO]};
                        prot_en_q <= sr_new_q[`ST_PROT_EN];
                    end
                end
            end
        end
    end

endmodule

`default_nettype wire

/* File: spi_master.sv */
// mode 0 serial master standing on the far side of the sequencer
`timescale 1ns/1ps
`default_nettype none
module spi_master (
    input wire logic so,
    output logic cs_n,
    output logic sck,
    output logic si
);
    // idle: deselected, clock parked low
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
    end
    // select; clock stays still until the first bit
    task automatic sel();
        cs_n = 1'b0;
        #800;
    endtask
    // one byte each way, msb first, so taken on the rising clock
    task automatic xb(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            si = tx[i];
            #400 sck = 1'b1;
            rx[i] = so;
            #400 sck = 1'b0;
        end
    endtask
    // deselect in the low phase after the last bit, then idle
    task automatic desel();
        #200 cs_n = 1'b1;
        si = ~si;
        #800;
    endtask
endmodule
`default_nettype wire

/* File: tb.sv */
// self-checking bench for the eeprom sequencer with a reference model
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin \
    $display("[FAIL] %0t %h %h", $time, a, b); n_errors++; end end
module tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic prot_n = 1'b1;
    logic ce = 1'b1;
    wire so, so_oe, write_busy, cs_n, sck, si;
    int n_errors = 0;
    int tests_run = 0;
    integer seed = 35158;
    logic [7:0] mem [int];
    logic latch = 1'b0;
    logic pen = 1'b0;
    logic [1:0] guard = 2'h0;
    logic [7:0] r;
    spi_eeprom_rw_sequencer #(.WC_CYCLES(600)) spi_eeprom_rw_sequencer_inst (.clk(clk),
        .rst_n(rst_n), .ce(ce), .cs_n(cs_n), .sck(sck), .si(si), .protect_pin_n(prot_n),
        .so(so), .so_oe(so_oe), .write_busy(write_busy));
    spi_master spi_master_inst (.so(so), .cs_n(cs_n), .sck(sck), .si(si));
    // 10 MHz clock
    initial forever #50 clk = ~clk;
    // byte helpers
    task automatic x(input logic [7:0] t);
        spi_master_inst.xb(t, r);
    endtask
    task automatic op(input logic [7:0] c);
        spi_master_inst.sel();
        x(c | (8'h08 & 8'($random(seed))));
    endtask
    task automatic adr(input logic [15:0] a);
        x(a[15:8]);
        x(a[7:0]);
    endtask
    // status byte read twice in one frame
    task automatic st(input logic bz);
        op(8'h05);
        repeat (2) begin
            x(8'($random(seed)));
            `CHK(r, (bz ? 8'hFF : {pen, 3'h0, guard, latch, 1'b0}))
        end
        spi_master_inst.desel();
    endtask
    task automatic lat(input logic v);
        op(v ? 8'h06 : 8'h04);
        spi_master_inst.desel();
        latch = v;
    endtask
    // end of a programming frame, busy probing, wait for the cycle end
    task automatic done(input logic go);
        spi_master_inst.desel();
        `CHK(write_busy, go)
        if (go) begin
            st(1'b1);
            op(8'h03);
            adr(16'h0000);
            x(8'h00);
            `CHK(so_oe, 1'b0)
            spi_master_inst.desel();
            for (int k = 0; k < 700 && write_busy; k++) @(posedge clk);
            @(posedge clk);
            #37;
            `CHK(write_busy, 1'b0)
            latch = 1'b0;
            st(1'b0);
        end
    endtask
    task automatic wr(input logic [15:0] a, input int n);
        logic go;
        logic [7:0] d;
        go = latch && !(guard == 3 || guard == 2 && a[15] || guard == 1 && &a[15:14]);
        op(8'h02);
        adr(a);
        for (int i = 0; i < n; i++) begin
            d = 8'($random(seed));
            x(d);
            if (go) mem[{a[15:7], 7'(a[6:0] + i)}] = d;
        end
        done(go);
    endtask
    task automatic rd(input logic [15:0] a, input int n);
        op(8'h03);
        adr(a);
        for (int i = 0; i < n; i++) begin
            x(8'($random(seed)));
            `CHK(r, mem[16'(a + i)])
        end
        spi_master_inst.desel();
    endtask
    task automatic sw(input logic [7:0] v);
        logic go;
        go = latch && !(pen && !prot_n);
        op(8'h01);
        x(v);
        if (go) {pen, guard} = {v[7], v[3:2]};
        done(go);
    endtask
    task automatic close_out();
        if (n_errors == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (4) @(posedge clk);
        #37 rst_n = 1'b1;
        st(1'b0);
        lat(1'b1);
        // clock enable low while idle: all state must be kept
        ce = 1'b0;
        repeat (6) @(posedge clk);
        #37 ce = 1'b1;
        st(1'b0);
        lat(1'b0);
        lat(1'b1);
        wr(16'h127E, 130);
        rd(16'h127E, 2);
        rd(16'h1200, 3);
        wr(16'h1210, 1);
        rd(16'h1210, 1);
        lat(1'b1);
        wr(16'hFFFF, 1);
        lat(1'b1);
        wr(16'h0000, 1);
        rd(16'hFFFF, 2);
        lat(1'b1);
        sw(8'h04);
        lat(1'b1);
        wr(16'hC000, 1);
        wr(16'hFFFF, 1);
        rd(16'hFFFF, 1);
        wr(16'hBFFF, 1);
        rd(16'hBFFF, 1);
        lat(1'b1);
        sw(8'h88);
        prot_n = 1'b0;
        lat(1'b1);
        sw(8'h00);
        st(1'b0);
        wr(16'h8000, 1);
        prot_n = 1'b1;
        sw(8'h0C);
        lat(1'b1);
        wr(16'h0100, 1);
        close_out();
    end
    // watchdog
    initial begin
        #8000000;
        n_errors++;
        close_out();
    end
endmodule
`default_nettype wire
